// File: design/tcs_pkg.sv
// constants and types for the timer-channel synchronous serial function
// assumes a 250 MHz system clock and a separate link clock for the shifter
package tcs_pkg;
    localparam int WORD_W = 16;              // shared serial shift word
    localparam int CNT_W = 5;                // bit count 1..16
    localparam int HALF_W = 16;              // half-bit time in link clocks
    localparam int FIFO_DEPTH = 4;           // transmit words queued ahead
    localparam int FN_W = 4;
    // function number given to this channel function (arbitrary value)
    localparam logic [FN_W-1:0] SSF_FN_NUM = 4'hA;
    localparam logic [1:0] HSR_START = 2'h3;     // host service: start
    localparam logic [1:0] PRIO_OFF = 2'h0;      // channel disabled
    // host-sequence encodings of the operating mode
    localparam logic [1:0] MODE_CLK_ONLY = 2'h0;
    localparam logic [1:0] MODE_IN_ONLY = 2'h1;
    localparam logic [1:0] MODE_OUT_ONLY = 2'h2;
    localparam logic [1:0] MODE_BIDIR = 2'h3;
    // reset values and unit constants
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
    localparam logic [HALF_W-1:0] HALF_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    typedef enum logic [1:0] {H_IDLE, H_WAIT_DATA, H_BUSY} tcs_host_e;
endpackage : tcs_pkg

// File: design/tcs_fifo_if.sv
// push/pop handshake bundle between the top and its transmit fifo
// assumes both sides run on ref_clk
`timescale 1ns/1ps
interface tcs_fifo_if #(parameter int W = 16);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport store (input push_valid, input push_data, input pop_ready,
                   output push_ready, output pop_valid, output pop_data);
    modport user (output push_valid, output push_data, output pop_ready,
                  input push_ready, input pop_valid, input pop_data);
endinterface : tcs_fifo_if

// File: design/tcs_fifo.sv
// small synchronous fifo holding words queued for the shift word
// assumes a single clock, synchronous active-low reset, clock enable
`timescale 1ns/1ps
module tcs_fifo
    import tcs_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    tcs_fifo_if.store fif
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    // handshake: honest full and empty
    assign fif.push_ready = (cnt_r != (AW+1)'(DEPTH));
    assign fif.pop_valid = (cnt_r != '0);
    assign fif.pop_data = mem_r[rd_r];
    assign do_push = fif.push_valid && fif.push_ready;
    assign do_pop = fif.pop_valid && fif.pop_ready;

    // next pointers, count and storage
    always_comb begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        mem_nxt = mem_r;
        if (do_push) begin
            mem_nxt[wr_r] = fif.push_data;
            wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
        end
        if (do_pop) begin
            rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
        end
        if (do_push && !do_pop) begin
            cnt_nxt = cnt_r + (AW+1)'(1);
        end else if (do_pop && !do_push) begin
            cnt_nxt = cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (clk_en) begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; empty flag guards stale words
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            mem_r <= mem_nxt;
        end
    end
endmodule : tcs_fifo

// File: design/tcs_top.sv
// synchronous serial function on a clock channel plus data channels
// assumes link_clk is free running; control is by plain ports
// Function
// RQ1 - shift out one end of the shift word, shift received bits into other
// RQ2 - output-only mode shifts zeros in instead of received bits
// RQ3 - input-only mode still shifts; bits shifted out are discarded
// RQ4 - clock-only mode keeps shifting the word while generating the clock
// RQ5 - no realignment; partial transfers leave data at word ends
// RQ6 - host touches the shift word only between transfers
// RQ7 - host disables channel, selects function, writes pin control
// RQ8 - host writes half-bit time, direction, bit count, then data
// RQ9 - host sets mode, issues service request 3, then enables priority
// RQ10 - after setup perform the transfer and flag completion
// RQ11 - later transfers: write new data then service request 3
// RQ12 - input or clock-only transfers start with service request alone
// RQ13 - two channels for one direction, three for bidirectional
// RQ14 - clock toggles each half-bit time; bit per period; stop at count
`timescale 1ns/1ps
module tcs_top
    import tcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire logic [1:0] channel_priority,
    input wire logic [FN_W-1:0] function_select,
    input wire logic [1:0] pin_control,
    input wire logic [HALF_W-1:0] half_bit_time,
    input wire logic shift_lsb_first,
    input wire logic [CNT_W-1:0] transfer_bit_count,
    input wire logic [1:0] host_sequence,
    input wire logic host_service_strobe,
    input wire logic [1:0] host_service_request_code,
    input wire logic data_wr_valid,
    input wire logic [WORD_W-1:0] data_wr_word,
    output logic data_wr_ready,
    output logic [WORD_W-1:0] serial_shift_word,
    output logic xfer_done,
    output logic busy,
    output logic [1:0] channels_used,
    output logic sclk_out,
    output logic sclk_oe,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic sdi_in
);
    tcs_fifo_if #(.W(WORD_W)) fif ();

    tcs_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .fif(fif)
    );

    // writes queue ahead so a busy transfer stalls the writer only once the fifo is full
    assign fif.push_valid = data_wr_valid;
    assign fif.push_data = data_wr_word;
    assign data_wr_ready = fif.push_ready;

    // link results read by the host; declared early as both sides use them
    logic [WORD_W-1:0] lnk_word_r, lnk_word_nxt;
    logic lnk_done_tgl_r, lnk_done_tgl_nxt;

    // host domain state
    tcs_host_e hst_r, hst_nxt;
    // request parked while the channel has no priority yet
    logic pend_r, pend_nxt;
    logic start_tgl_r, start_tgl_nxt;
    logic load_r, load_nxt;
    logic [WORD_W-1:0] tx_hold_r, tx_hold_nxt;
    logic [WORD_W-1:0] rx_word_r, rx_word_nxt;
    logic done_r, done_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic lsb_r, lsb_nxt;
    logic [CNT_W-1:0] nbit_r, nbit_nxt;
    logic [HALF_W-1:0] half_r, half_nxt;
    logic [2:0] dsy_r;
    logic svc_req, start_req, uses_out, done_seen;

    // service request 3; setup raises priority only after it, so a
    // request on a disabled channel is parked instead of being lost
    assign svc_req = host_service_strobe
        && (host_service_request_code == HSR_START);
    assign start_req = (svc_req || pend_r)
        && (channel_priority != PRIO_OFF)
        && (function_select == SSF_FN_NUM); // [RQ9] [RQ10]
    assign uses_out = (host_sequence == MODE_OUT_ONLY)
        || (host_sequence == MODE_BIDIR);
    // done arrives as a toggle so no pulse is missed across clocks
    assign done_seen = dsy_r[2] ^ dsy_r[1];
    assign fif.pop_ready = (hst_r == H_WAIT_DATA);

    // host sequencer: wait for data if output is used, then launch
    always_comb begin
        hst_nxt = hst_r;
        start_tgl_nxt = start_tgl_r;
        load_nxt = load_r;
        tx_hold_nxt = tx_hold_r;
        rx_word_nxt = rx_word_r;
        done_nxt = 1'b0;
        mode_nxt = mode_r;
        lsb_nxt = lsb_r;
        nbit_nxt = nbit_r;
        half_nxt = half_r;
        pend_nxt = pend_r;
        unique case (hst_r)
            H_IDLE: begin
                if (start_req) begin
                    // config is snapshotted, stable through the transfer
                    pend_nxt = 1'b0;
                    mode_nxt = host_sequence;
                    lsb_nxt = shift_lsb_first;
                    nbit_nxt = (transfer_bit_count == CNT_RST) ?
                        CNT_ONE : transfer_bit_count;
                    half_nxt = (half_bit_time == HALF_RST) ?
                        HALF_ONE : half_bit_time;
                    if (uses_out) begin
                        hst_nxt = H_WAIT_DATA;                 // [RQ11]
                    end else begin
                        load_nxt = 1'b0;                       // [RQ12]
                        start_tgl_nxt = ~start_tgl_r;
                        hst_nxt = H_BUSY;
                    end
                end else if (svc_req && function_select == SSF_FN_NUM) begin
                    pend_nxt = 1'b1;                           // [RQ9]
                end
            end
            H_WAIT_DATA: begin
                if (fif.pop_valid) begin
                    tx_hold_nxt = fif.pop_data;
                    load_nxt = 1'b1;
                    start_tgl_nxt = ~start_tgl_r;
                    hst_nxt = H_BUSY;
                end else if (channel_priority == PRIO_OFF) begin
                    hst_nxt = H_IDLE;                          // [RQ7]
                end
            end
            H_BUSY: begin
                if (done_seen) begin
                    // link word is stable here: the link has gone idle
                    rx_word_nxt = lnk_word_r;                  // [RQ6]
                    done_nxt = 1'b1;                           // [RQ10]
                    hst_nxt = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hst_r <= H_IDLE;
            pend_r <= 1'b0;
            start_tgl_r <= 1'b0;
            load_r <= 1'b0;
            tx_hold_r <= WORD_RST;
            rx_word_r <= WORD_RST;
            done_r <= 1'b0;
            mode_r <= MODE_CLK_ONLY;
            lsb_r <= 1'b0;
            nbit_r <= CNT_RST;
            half_r <= HALF_RST;
        end else if (clk_en) begin
            hst_r <= hst_nxt;
            pend_r <= pend_nxt;
            start_tgl_r <= start_tgl_nxt;
            load_r <= load_nxt;
            tx_hold_r <= tx_hold_nxt;
            rx_word_r <= rx_word_nxt;
            done_r <= done_nxt;
            mode_r <= mode_nxt;
            lsb_r <= lsb_nxt;
            nbit_r <= nbit_nxt;
            half_r <= half_nxt;
        end
    end

    // done toggle from the link, two stages then edge detect
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dsy_r <= 3'h0;
        end else if (clk_en) begin
            dsy_r <= {dsy_r[1:0], lnk_done_tgl_r};
        end
    end

    assign serial_shift_word = rx_word_r;
    assign xfer_done = done_r;
    assign busy = (hst_r != H_IDLE);
    // clock channel plus one data channel per direction in use
    assign channels_used = (mode_r == MODE_BIDIR) ? 2'h3 :
        ((mode_r == MODE_CLK_ONLY) ? 2'h1 : 2'h2);             // [RQ13]
    // pin driven only while the channel is enabled and the pin is given
    assign sclk_oe = (channel_priority != PRIO_OFF) && pin_control[0];

    // link domain: reset, enable, start toggle and data pin synchronisers
    // no reset here: nrst itself reaches the link through these flops
    logic [1:0] lrst_sy_r, len_sy_r;
    logic [2:0] ssy_r;
    logic [1:0] sdi_sy_r;
    logic lrst_n, len;
    assign lrst_n = lrst_sy_r[1];
    assign len = len_sy_r[1];

    always_ff @(posedge link_clk) begin
        lrst_sy_r <= {lrst_sy_r[0], nrst};
        len_sy_r <= {len_sy_r[0], clk_en};
        ssy_r <= {ssy_r[1:0], start_tgl_r};
        sdi_sy_r <= {sdi_sy_r[0], sdi_in};
    end

    // link shifter state
    logic lnk_run_r, lnk_run_nxt;
    logic lnk_sclk_r, lnk_sclk_nxt;
    logic [HALF_W-1:0] lnk_hcnt_r, lnk_hcnt_nxt;
    logic [CNT_W-1:0] lnk_bits_r, lnk_bits_nxt;
    logic lnk_in_r, lnk_in_nxt;
    logic lnk_sdo_r, lnk_sdo_nxt;
    logic lnk_start, in_bit, out_bit;

    // host config regs only change while this side is idle
    // start edge seen once the toggle has crossed two flops
    assign lnk_start = ssy_r[2] ^ ssy_r[1];
    // output-only and clock-only modes feed zeros instead of the data pin
    assign in_bit = (mode_r == MODE_OUT_ONLY || mode_r == MODE_CLK_ONLY) ?
        1'b0 : lnk_in_r;                                       // [RQ2]
    assign out_bit = lsb_r ? lnk_word_r[0] : lnk_word_r[WORD_W-1];

    // clock low idle; sample on rise, shift on fall
    always_comb begin
        lnk_run_nxt = lnk_run_r;
        lnk_sclk_nxt = lnk_sclk_r;
        lnk_hcnt_nxt = lnk_hcnt_r;
        lnk_bits_nxt = lnk_bits_r;
        lnk_word_nxt = lnk_word_r;
        lnk_in_nxt = lnk_in_r;
        lnk_sdo_nxt = lnk_sdo_r;
        lnk_done_tgl_nxt = lnk_done_tgl_r;
        if (!lnk_run_r) begin
            if (lnk_start) begin
                // data without a fresh load keeps the previous word
                if (load_r) begin
                    lnk_word_nxt = tx_hold_r;
                end
                lnk_sdo_nxt = load_r ? (lsb_r ? tx_hold_r[0] :
                    tx_hold_r[WORD_W-1]) : out_bit;
                lnk_run_nxt = 1'b1;
                lnk_hcnt_nxt = half_r;
                lnk_bits_nxt = CNT_RST;
                lnk_sclk_nxt = 1'b0;
            end
        end else if (lnk_hcnt_r != HALF_ONE) begin
            lnk_hcnt_nxt = lnk_hcnt_r - HALF_ONE;
        end else begin
            lnk_hcnt_nxt = half_r;
            lnk_sclk_nxt = ~lnk_sclk_r;                        // [RQ14]
            if (!lnk_sclk_r) begin
                lnk_in_nxt = sdi_sy_r[1];
            end else begin
                // shift every mode; out end bit simply drops off
                if (lsb_r) begin
                    lnk_word_nxt = {in_bit, lnk_word_r[WORD_W-1:1]};
                end else begin
                    lnk_word_nxt = {lnk_word_r[WORD_W-2:0], in_bit};
                end // [RQ1] [RQ3] [RQ4] [RQ5]
                lnk_sdo_nxt = lsb_r ? lnk_word_r[1] :
                    lnk_word_r[WORD_W-2];
                lnk_bits_nxt = lnk_bits_r + CNT_ONE;
                if (lnk_bits_r + CNT_ONE == nbit_r) begin
                    lnk_run_nxt = 1'b0;                        // [RQ14]
                    lnk_done_tgl_nxt = ~lnk_done_tgl_r;        // [RQ10]
                end
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            lnk_run_r <= 1'b0;
            lnk_sclk_r <= 1'b0;
            lnk_hcnt_r <= HALF_RST;
            lnk_bits_r <= CNT_RST;
            lnk_word_r <= WORD_RST;
            lnk_in_r <= 1'b0;
            lnk_sdo_r <= 1'b0;
            lnk_done_tgl_r <= 1'b0;
        end else if (len) begin
            lnk_run_r <= lnk_run_nxt;
            lnk_sclk_r <= lnk_sclk_nxt;
            lnk_hcnt_r <= lnk_hcnt_nxt;
            lnk_bits_r <= lnk_bits_nxt;
            lnk_word_r <= lnk_word_nxt;
            lnk_in_r <= lnk_in_nxt;
            lnk_sdo_r <= lnk_sdo_nxt;
            lnk_done_tgl_r <= lnk_done_tgl_nxt;
        end
    end

    assign sclk_out = lnk_sclk_r;
    // data-out channel drives only where output is used
    assign sdo_out = (mode_r == MODE_OUT_ONLY || mode_r == MODE_BIDIR) ?
        lnk_sdo_r : 1'b0;                                      // [RQ3]
    assign sdo_oe = (mode_r == MODE_OUT_ONLY || mode_r == MODE_BIDIR)
        && (channel_priority != PRIO_OFF);                     // [RQ13]
endmodule : tcs_top

// File: tb/tcs_top_monitor.sv
// port checker for the serial function top
// assumes the ref_clk domain; bound from the testbench top
`timescale 1ns/1ps
module tcs_top_monitor
    import tcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] channel_priority,
    input wire logic [FN_W-1:0] function_select,
    input wire logic [1:0] pin_control,
    input wire logic [1:0] host_sequence,
    input wire logic host_service_strobe,
    input wire logic [1:0] host_service_request_code,
    input wire logic data_wr_ready,
    input wire logic [WORD_W-1:0] serial_shift_word,
    input wire logic xfer_done,
    input wire logic busy,
    input wire logic [1:0] channels_used,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic sdo_oe
);
    logic take;
    logic [1:0] ch_exp;
    logic parked, woke;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // start request as the top should see it
    assign take = host_service_strobe && !busy &&
        host_service_request_code == HSR_START &&
        channel_priority != PRIO_OFF;
    // channel count by mode; clock-only needs just the clock channel
    assign ch_exp = (host_sequence == MODE_BIDIR) ? 2'h3 :
        (host_sequence == MODE_CLK_ONLY) ? 2'h1 : 2'h2;
    // request on a disabled channel, then priority raised
    assign parked = host_service_strobe && !busy &&
        host_service_request_code == HSR_START &&
        channel_priority == PRIO_OFF && function_select == SSF_FN_NUM;
    assign woke = channel_priority != PRIO_OFF &&
        function_select == SSF_FN_NUM;
    a_pend_start: assert property (parked ##1 woke |=> busy)
        else $error("parked request not started");
    a_start_busy: assert property (take && function_select == SSF_FN_NUM
        |=> busy) else $error("start not taken");
    a_fn_refused: assert property (take && function_select != SSF_FN_NUM
        |=> !busy) else $error("foreign function started");
    a_done_pulse: assert property (xfer_done |=> !xfer_done)
        else $error("done longer than one cycle");
    a_done_idle: assert property (xfer_done |=> !busy)
        else $error("busy after done");
    a_word_hold: assert property ($changed(serial_shift_word) |->
        xfer_done || $past(xfer_done))
        else $error("word changed mid transfer");
    a_sclk_idle: assert property (!busy |-> !sclk_out)
        else $error("clock moves while idle");
    a_sclk_drive: assert property (sclk_oe == (pin_control[0] &&
        channel_priority != PRIO_OFF)) else $error("sclk enable");
    a_chan_count: assert property ($rose(busy) |=> channels_used == ch_exp)
        else $error("channel count");
    a_sdo_off: assert property (channel_priority == PRIO_OFF |-> !sdo_oe)
        else $error("data driven while disabled");
    c_bidir: cover property (xfer_done && channels_used == 2'h3);
    c_refused: cover property (take && function_select != SSF_FN_NUM);
    c_full: cover property (!data_wr_ready);
    c_parked: cover property (parked ##1 woke);
endmodule : tcs_top_monitor

// File: tb/tcs_peer.sv
// external serial peripheral on the far side of the link pins
// assumes sample on sclk rise, shift on sclk fall, no select line
`timescale 1ns/1ps
module tcs_peer
    import tcs_pkg::*;
(
    input wire logic sclk,
    input wire logic sdo,
    input wire logic active,
    input wire logic lsb_first,
    input wire logic load,
    input wire logic [WORD_W-1:0] tx_word,
    output logic sdi,
    output logic [WORD_W-1:0] rx_word
);
    logic [WORD_W-1:0] tx_r = 16'h0000;
    logic last_r = 1'b0;
    // released line shows the inverse, so a stale bit cannot pass
    assign sdi = active ? (lsb_first ? tx_r[0] : tx_r[WORD_W-1]) : ~last_r;
    // next bit after each falling clock edge
    always @(posedge load or negedge sclk) begin
        if (load) begin
            tx_r <= tx_word;
        end else begin
            last_r <= sdi;
            tx_r <= lsb_first ? {1'b0, tx_r[WORD_W-1:1]} :
                {tx_r[WORD_W-2:0], 1'b0};
        end
    end
    // capture on rise, same shift direction as the device
    always @(posedge sclk or posedge load) begin
        if (load) begin
            rx_word <= 16'h0000;
        end else begin
            rx_word <= lsb_first ? {sdo, rx_word[WORD_W-1:1]} :
                {rx_word[WORD_W-2:0], sdo};
        end
    end
endmodule : tcs_peer

// File: tb/tb_tcs_top.sv
// testbench for the serial function top with a peripheral model
// assumes 4 ns ref_clk, free running 30 ns link clock
`timescale 1ns/1ps
module tb_tcs_top;
    import tcs_pkg::*;
    logic ref_clk = 0, link_clk = 0, nrst = 0, lsb = 0, strobe = 0;
    logic [1:0] prio = 2'h0, pin_ctl = 2'h1, mode = 2'h0, code = 2'h0;
    logic [FN_W-1:0] fn = 4'h0;
    logic [CNT_W-1:0] nbits = 5'h01;
    logic wr_valid = 0, wr_ready, done, busy, sclk, sclk_oe, sdo, sdo_oe;
    logic sdi, p_load = 0;
    logic [WORD_W-1:0] wr_word = 16'h0000, word, p_tx = 16'h0000, p_rx;
    logic [1:0] chans;
    int failures = 0, cmp_count = 0, rises = 0;
    // clocks unrelated in phase
    initial forever #2 ref_clk = ~ref_clk;
    initial begin
        #1;
        forever #15 link_clk = ~link_clk;
    end
    always @(posedge sclk) rises++;
    tcs_top dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1),
        .link_clk(link_clk), .channel_priority(prio),
        .function_select(fn), .pin_control(pin_ctl),
        .half_bit_time(16'h0004), .shift_lsb_first(lsb),
        .transfer_bit_count(nbits), .host_sequence(mode),
        .host_service_strobe(strobe), .host_service_request_code(code),
        .data_wr_valid(wr_valid), .data_wr_word(wr_word),
        .data_wr_ready(wr_ready), .serial_shift_word(word),
        .xfer_done(done), .busy(busy), .channels_used(chans),
        .sclk_out(sclk), .sclk_oe(sclk_oe), .sdo_out(sdo),
        .sdo_oe(sdo_oe), .sdi_in(sdi));
    tcs_peer peer (.sclk(sclk), .sdo(sdo), .active(busy), .lsb_first(lsb),
        .load(p_load), .tx_word(p_tx), .sdi(sdi), .rx_word(p_rx));
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s exp %h got %h", name, exp, got);
        end
    endtask : check
    // push held until ready is seen at a rising edge
    task automatic push(logic [15:0] w);
        @(negedge ref_clk);
        wr_valid = 1;
        wr_word = w;
        do @(posedge ref_clk); while (wr_ready !== 1'b1);
        @(negedge ref_clk);
        wr_valid = 0;
    endtask : push
    // one start request, priority raised after it; checks done and rises
    task automatic xfer(logic [1:0] m, logic l, logic [4:0] n,
            logic [15:0] p, logic [1:0] pr);
        logic go, seen;
        go = (fn == SSF_FN_NUM) && (pr != PRIO_OFF);
        seen = 1'b0;
        @(negedge ref_clk);
        mode = m;
        lsb = l;
        nbits = n;
        p_tx = p;
        p_load = 1;
        @(negedge ref_clk);
        p_load = 0;
        rises = 0;
        strobe = 1;
        code = HSR_START;
        @(negedge ref_clk);
        strobe = 0;
        prio = pr;
        for (int i = 0; i < 3000 && !seen; i++) begin
            @(negedge ref_clk);
            seen = (done === 1'b1);
        end
        @(negedge ref_clk);
        check("done", {15'h0, go}, {15'h0, seen});
        check("bits", go ? {11'h000, n} : 16'h0000, rises[15:0]);
    endtask : xfer
    task automatic close_out();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // hang guard well beyond the expected run
    initial begin
        #150000;
        failures++;
        close_out();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        nrst = 1;
        repeat (40) @(negedge ref_clk);
        fn = 4'h5; // foreign function first, then disabled
        prio = 2'h1;
        xfer(MODE_CLK_ONLY, 1'b1, 5'h01, 16'h0000, 2'h1);
        check("busy wrong fn", 16'h0000, {15'h0, busy});
        prio = PRIO_OFF;
        fn = SSF_FN_NUM;
        xfer(MODE_CLK_ONLY, 1'b1, 5'h01, 16'h0000, PRIO_OFF);
        check("busy off", 16'h0000, {15'h0, busy});
        push(16'h1234);
        xfer(MODE_BIDIR, 1'b1, 5'h08, 16'h00C3, 2'h2);
        check("word 8 lsb", 16'hC312, word);
        check("peer 8 lsb", 16'h0034, {8'h00, p_rx[15:8]});
        push(16'hBEEF);
        xfer(MODE_BIDIR, 1'b0, 5'h10, 16'h5AA5, 2'h2);
        check("word 16 msb", 16'h5AA5, word);
        check("peer 16 msb", 16'hBEEF, p_rx);
        for (int k = 0; k < 4; k++) push(16'h1111 * (k + 1));
        check("ready full", 16'h0000, {15'h0, wr_ready});
        for (int k = 0; k < 4; k++) begin
            xfer(MODE_OUT_ONLY, 1'b1, 5'h10, 16'hFFFF, 2'h2);
            check("word out", 16'h0000, word);
            check("peer out", 16'h1111 * (k + 1), p_rx);
        end
        check("ready empty", 16'h0001, {15'h0, wr_ready});
        xfer(MODE_IN_ONLY, 1'b0, 5'h08, 16'hC700, 2'h2);
        check("word in", 16'h00C7, word);
        check("peer in", 16'h0000, {8'h00, p_rx[7:0]});
        xfer(MODE_CLK_ONLY, 1'b1, 5'h04, 16'hFFFF, 2'h2);
        check("word clk", 16'h000C, word);
        close_out();
    end
endmodule : tb_tcs_top
bind tcs_top tcs_top_monitor mon (.ref_clk(ref_clk), .nrst(nrst),
    .channel_priority(channel_priority), .function_select(function_select),
    .pin_control(pin_control), .host_sequence(host_sequence),
    .host_service_strobe(host_service_strobe),
    .host_service_request_code(host_service_request_code),
    .data_wr_ready(data_wr_ready), .serial_shift_word(serial_shift_word),
    .xfer_done(xfer_done), .busy(busy), .channels_used(channels_used),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sdo_oe(sdo_oe));
